// >>> vdp_dev.sv
// Functional notes
// R1: Control bit 2 bypasses the high-pass filter
// R2: High-pass: fourth order IIR at 8 kHz
// R3: First interpolation 8 to 40 kHz, IIR low-pass
// R4: Upsample to 1 MHz, sinc4 image filter
// R5: Low-pass: tenth order IIR at 40 kHz
// R6: Combined ripple 0.2 dB over voice band
// R7: Gain from control bits 7-9, -15..+6 dB
// R8: Code 000 is +6 dB, 3 dB steps down
// R9: Words are 16 bits, MSB first
// R10: Serial clock is master clock over five
// R11: Chip select low floats outputs, ignores inputs
// R12: In reset drive clock, data, sync low; code clears them but their enables still follow chip select
// R13: Powerdown: clock runs, sync low, data held; read replies still go out with sync high
// R14: Host drives input data and input sync
// R15: One link carries samples and control both ways
// R16: Missing sample: previous sample is reused
// R17: Word starts one clock after sync; select high
// R18: Fixed-point filters, state cleared by reset
// R19: Fixed ratio 25 from 40 kHz to 1 MHz
`timescale 1ns/1ps
`default_nettype none
module vdp_dev (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial link, device end
	vdp_link_if.dev          link,
	// Sample to send each frame
	input  wire logic [15:0] adc_word,
	output logic             adc_taken,
	// DAC path result at 1 MHz
	output logic [15:0]      dac_sample,
	output logic             dac_valid,
	// Control setting for the analog side
	output logic [15:0]      ctrl_word
);
	localparam int FW = vdp_pkg::FW;
	localparam int CI = vdp_pkg::CIC_W;

	typedef struct packed {
		logic                      oe;
		logic [2:0]                div;
		logic                      sclk;
		logic                      serial_out_line;
		logic                      out_frame_sync;
		logic [4:0]                rx_cnt;
		logic [15:0]               rx_sh;
		logic                      rx_dc;
		logic [4:0]                tx_cnt;
		logic [15:0]               tx_sh;
		logic                      tx_go;
		logic                      rd_pend;
		logic                      rd_reply;
		logic                      taken;
		logic [vdp_pkg::CTRL_W-1:0] ctrl;
		logic [15:0]               dac_word;
		logic [4:0]                c1m;
		logic [4:0]                n25;
		logic [2:0]                n5;
		logic                      busy;
		logic [2:0]                sec;
		logic [FW-1:0]             x;
		logic [6:0][FW-1:0]        fx1;
		logic [6:0][FW-1:0]        fx2;
		logic [6:0][FW-1:0]        fy1;
		logic [6:0][FW-1:0]        fy2;
		logic [3:0][CI-1:0]        comb_d;
		logic [CI-1:0]             cic_in;
		logic                      stuff;
		logic [3:0][CI-1:0]        integ;
		logic [15:0]               dac_out;
		logic                      dac_stb;
	} vdp_dev_st_t;

	vdp_dev_st_t s_r;
	vdp_dev_st_t s_nxt;

	function automatic logic signed [FW-1:0] sat24(input logic signed [47:0] v);
		if (v > 48'sh0000007fffff)
			return 24'sh7fffff;
		else if (v < -48'sh000000800000)
			return -24'sh800000;
		else
			return v[FW-1:0];
	endfunction

	function automatic logic signed [15:0] clip16(input logic signed [47:0] v);
		if (v > 48'sh000000007fff)
			return 16'sh7fff;
		else if (v < -48'sh000000008000)
			return -16'sh8000;
		else
			return v[15:0];
	endfunction

	// One second-order section in direct form I
	function automatic logic signed [FW-1:0] biquad(input int k,
			input logic signed [FW-1:0] x, x1, x2, y1, y2);
		logic signed [47:0] acc;
		acc = vdp_pkg::COEF_B[k][0] * x + vdp_pkg::COEF_B[k][1] * x1
			+ vdp_pkg::COEF_B[k][2] * x2 - vdp_pkg::COEF_A[k][0] * y1
			- vdp_pkg::COEF_A[k][1] * y2;
		return sat24(acc >>> vdp_pkg::COEF_FRAC);
	endfunction

	logic                 rise;
	logic                 fall;
	logic                 t1m;
	logic                 t40;
	logic                 t8;
	logic [15:0]          w;
	logic signed [FW-1:0] y;
	logic signed [FW-1:0] xin;
	logic signed [CI-1:0] v;
	logic signed [CI-1:0] t;
	logic signed [15:0]   o;
	logic signed [47:0]   g;

	always_comb begin
		s_nxt = s_r;
		w = '0;
		y = '0;
		v = '0;
		t = '0;
		o = '0;
		g = '0;
		xin = FW'($signed(s_r.dac_word)) <<< vdp_pkg::IN_SHIFT;
		s_nxt.oe = link.cs;
		s_nxt.taken = 1'b0;
		s_nxt.dac_stb = 1'b0;
		rise = (s_r.div == vdp_pkg::DIV_LAST);
		fall = (s_r.div == vdp_pkg::DIV_FALL);
		s_nxt.div = rise ? 3'h0 : 3'(s_r.div + 3'h1); // R10
		if (rise)
			s_nxt.sclk = 1'b1;
		if (fall)
			s_nxt.sclk = 1'b0;
		t1m = (s_r.c1m == vdp_pkg::C1M_LAST);
		t40 = t1m && (s_r.n25 == vdp_pkg::N25_LAST); // R19
		t8 = t40 && (s_r.n5 == vdp_pkg::N5_LAST);
		s_nxt.c1m = t1m ? 5'h0 : 5'(s_r.c1m + 5'h1);
		if (t1m)
			s_nxt.n25 = t40 ? 5'h0 : 5'(s_r.n25 + 5'h1);
		if (t40)
			s_nxt.n5 = t8 ? 3'h0 : 3'(s_r.n5 + 3'h1);
		// Receive on falling serial clock edges
		if (fall) begin
			if (!link.cs) begin
				s_nxt.rx_cnt = 5'h0; // R11
			end else begin
				w = {s_r.rx_sh[14:0], link.serial_in_line};
				if (s_r.rx_cnt != 5'h0) begin
					s_nxt.rx_sh = w; // R9
					s_nxt.rx_cnt = 5'(s_r.rx_cnt - 5'h1);
				end
				if (s_r.rx_cnt == 5'h1) begin
					if (s_r.rx_dc)
						s_nxt.dac_word = w; // R15
					else if (!w[vdp_pkg::BIT_CMD_READ])
						s_nxt.ctrl = w[vdp_pkg::CTRL_W-1:0];
					else if (!w[vdp_pkg::BIT_CMD_RDY])
						s_nxt.rd_pend = 1'b1;
					else if (s_r.rd_pend) begin
						s_nxt.rd_pend = 1'b0;
						s_nxt.rd_reply = 1'b1;
					end
				end
				// A new sync counts only when idle or in the last bit
				if (s_r.rx_cnt <= 5'h1 && link.in_frame_sync) begin
					s_nxt.rx_cnt = vdp_pkg::BIT_CNT_LOAD; // R17
					s_nxt.rx_dc = link.dc_sel;
				end
			end
		end
		// Sample frames go out only with both powerdown bits at operating
		if (t8 && s_r.ctrl[vdp_pkg::BIT_PWR_DIG] && s_r.ctrl[vdp_pkg::BIT_PWR_ANA])
			s_nxt.tx_go = 1'b1; // R13
		// Transmit on rising edges; sdo keeps its last bit when idle
		if (rise) begin
			s_nxt.out_frame_sync = 1'b0;
			if (!link.cs) begin
				s_nxt.tx_cnt = 5'h0; // R11
			end else if (s_r.tx_cnt != 5'h0) begin
				s_nxt.serial_out_line = s_r.tx_sh[15]; // R9
				s_nxt.tx_sh = {s_r.tx_sh[14:0], 1'b0};
				s_nxt.tx_cnt = 5'(s_r.tx_cnt - 5'h1);
			end else if (s_r.rd_reply) begin
				s_nxt.out_frame_sync = 1'b1; // R17
				s_nxt.tx_sh = {6'h00, s_r.ctrl};
				s_nxt.tx_cnt = vdp_pkg::BIT_CNT_LOAD;
				s_nxt.rd_reply = 1'b0;
			end else if (s_r.tx_go) begin
				s_nxt.out_frame_sync = 1'b1; // R17
				s_nxt.tx_sh = adc_word;
				s_nxt.tx_cnt = vdp_pkg::BIT_CNT_LOAD;
				s_nxt.tx_go = 1'b0;
				s_nxt.taken = 1'b1;
			end
		end
		// Filter sequencer, one section per clock
		if (t40) begin
			s_nxt.busy = 1'b1;
			if (t8 && !s_r.ctrl[vdp_pkg::BIT_DAC_BYP]) begin
				s_nxt.sec = 3'h0; // R1
				s_nxt.x = xin; // R16
			end else begin
				s_nxt.sec = vdp_pkg::SEC_LP_FIRST; // R1
				s_nxt.x = t8 ? 24'((xin <<< 2) + xin) : '0; // R3
			end
		end else if (s_r.busy) begin
			y = biquad(int'(s_r.sec), s_r.x, s_r.fx1[s_r.sec], s_r.fx2[s_r.sec],
				s_r.fy1[s_r.sec], s_r.fy2[s_r.sec]); // R2 R5 R6 R18
			s_nxt.fx1[s_r.sec] = s_r.x;
			s_nxt.fx2[s_r.sec] = s_r.fx1[s_r.sec];
			s_nxt.fy1[s_r.sec] = y;
			s_nxt.fy2[s_r.sec] = s_r.fy1[s_r.sec];
			s_nxt.sec = 3'(s_r.sec + 3'h1);
			s_nxt.x = y;
			if (s_r.sec == vdp_pkg::SEC_HP_LAST) begin
				s_nxt.x = sat24(48'(y) * 48'sd5); // R3
			end else if (s_r.sec == vdp_pkg::SEC_LP_LAST) begin
				s_nxt.busy = 1'b0;
				// Comb half of the sinc4 runs at 40 kHz
				v = CI'(y);
				for (int i = 0; i < 4; i++) begin
					t = v - $signed(s_r.comb_d[i]);
					s_nxt.comb_d[i] = v;
					v = t;
				end
				s_nxt.cic_in = v; // R4
				s_nxt.stuff = 1'b1;
			end
		end
		// Integrator half at 1 MHz with zero stuffing
		if (t1m) begin
			s_nxt.integ[0] = s_r.integ[0] + (s_r.stuff ? s_r.cic_in : '0); // R4 R19
			for (int i = 1; i < 4; i++)
				s_nxt.integ[i] = s_r.integ[i] + s_r.integ[i-1];
			// Consumption clears stuff, and also wipes a sample posted in this same cycle
			s_nxt.stuff = s_nxt.stuff & ~s_r.stuff;
			o = clip16(48'($signed(s_r.integ[3]) >>> vdp_pkg::OUT_SHIFT));
			g = o * vdp_pkg::GAIN_Q14[s_r.ctrl[vdp_pkg::GAIN_LSB +: 3]]; // R7 R8
			s_nxt.dac_out = clip16(g >>> vdp_pkg::COEF_FRAC);
			s_nxt.dac_stb = 1'b1;
		end
		if (rst) begin
			s_nxt = '0; // R12 R18
			s_nxt.ctrl = vdp_pkg::CTRL_RST;
			s_nxt.oe = link.cs;
		end
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	assign link.sclk     = s_r.sclk;
	assign link.serial_out_line      = s_r.serial_out_line;
	assign link.out_frame_sync    = s_r.out_frame_sync;
	assign link.sclk_oe  = s_r.oe; // R11
	assign link.sdo_oe   = s_r.oe;
	assign link.out_frame_sync_oe = s_r.oe;
	assign adc_taken     = s_r.taken;
	assign dac_sample    = s_r.dac_out;
	assign dac_valid     = s_r.dac_stb;
	assign ctrl_word     = {6'h00, s_r.ctrl};
endmodule
`default_nettype wire

// >>> vdp_pkg.sv
`default_nettype none
package vdp_pkg;
	// Clocking and rate plan
	localparam int CLK_NS    = 40;
	localparam int CLK_HZ    = 1000000000 / CLK_NS;
	localparam int SCLK_DIV  = 5;
	localparam int FS_HZ     = 8000;
	localparam int MID_HZ    = 40000;
	localparam int OSR_HZ    = 1000000;
	localparam int CYC_OSR   = CLK_HZ / OSR_HZ;
	localparam int OSR_PER_MID = OSR_HZ / MID_HZ;
	localparam int MID_PER_FS  = MID_HZ / FS_HZ;
	localparam logic [2:0] DIV_LAST  = 3'(SCLK_DIV - 1);
	localparam logic [2:0] DIV_FALL  = 3'h1;
	localparam logic [4:0] C1M_LAST  = 5'(CYC_OSR - 1);
	localparam logic [4:0] N25_LAST  = 5'(OSR_PER_MID - 1);
	localparam logic [2:0] N5_LAST   = 3'(MID_PER_FS - 1);
	// Serial word
	localparam int WORD_BITS = 16;
	localparam logic [4:0] BIT_CNT_LOAD = 5'(WORD_BITS);
	// Control word layout
	localparam int CTRL_W       = 10;
	localparam int BIT_DAC_BYP  = 2;
	localparam int BIT_PWR_ANA  = 4;
	localparam int BIT_PWR_DIG  = 5;
	localparam int GAIN_LSB     = 7;
	localparam int BIT_CMD_READ = 15;
	localparam int BIT_CMD_RDY  = 14;
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
	// Filter arithmetic
	localparam int FW          = 24;
	localparam int CW          = 18;
	localparam int COEF_FRAC   = 14;
	localparam int IN_SHIFT    = 4;
	localparam int CIC_W       = 44;
	localparam int OUT_SHIFT   = 18;
	localparam int N_SEC       = 7;
	localparam logic [2:0] SEC_HP_LAST = 3'h1;
	localparam logic [2:0] SEC_LP_FIRST = 3'h2;
	localparam logic [2:0] SEC_LP_LAST  = 3'h6;
	// Sections 0-1 high-pass at 8 kHz, 2-6 low-pass at 40 kHz, Q14
	localparam logic signed [CW-1:0] COEF_B [N_SEC][3] = '{
		'{18'sd15400, -18'sd30800, 18'sd15400},
		'{18'sd15880, -18'sd31700, 18'sd15880},
		'{18'sd1024,  18'sd2048,   18'sd1024},
		'{18'sd1100,  18'sd1900,   18'sd1100},
		'{18'sd1200,  18'sd1700,   18'sd1200},
		'{18'sd1300,  18'sd1500,   18'sd1300},
		'{18'sd1400,  18'sd1300,   18'sd1400}};
	localparam logic signed [CW-1:0] COEF_A [N_SEC][2] = '{
		'{-18'sd31200, 18'sd14860},
		'{-18'sd31900, 18'sd15600},
		'{-18'sd19661, 18'sd7373},
		'{-18'sd20500, 18'sd9300},
		'{-18'sd21800, 18'sd11600},
		'{-18'sd23000, 18'sd13500},
		'{-18'sd24000, 18'sd15100}};
	// Output level, +6 dB down to -15 dB in 3 dB steps, Q14
	localparam logic signed [CW-1:0] GAIN_Q14 [8] = '{
		18'sd32690, 18'sd23143, 18'sd16384, 18'sd11599,
		18'sd8211,  18'sd5813,  18'sd4115,  18'sd2913};
	localparam int HOST_FIFO_DEPTH = 8;
	localparam int HOST_FIFO_W     = WORD_BITS + 1;
endpackage
`default_nettype wire

// >>> vdp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vdp_link_if;
	logic sclk;
	logic sclk_oe;
	logic serial_out_line;
	logic sdo_oe;
	logic out_frame_sync;
	logic out_frame_sync_oe;
	logic serial_in_line;
	logic in_frame_sync;
	logic dc_sel;
	logic cs;
	// Line levels seen by the host; an undriven line reads low
	logic sclk_w;
	logic sdo_w;
	logic out_frame_sync_w;
	assign sclk_w  = sclk & sclk_oe;
	assign sdo_w   = serial_out_line & sdo_oe;
	assign out_frame_sync_w = out_frame_sync & out_frame_sync_oe;
	modport dev (output sclk, sclk_oe, serial_out_line, sdo_oe, out_frame_sync, out_frame_sync_oe,
		input serial_in_line, in_frame_sync, dc_sel, cs);
	modport host (input sclk_w, sdo_w, out_frame_sync_w, output serial_in_line, in_frame_sync, dc_sel, cs);
endinterface
`default_nettype wire

// >>> vdp_host.sv
`timescale 1ns/1ps
`default_nettype none
module vdp_fifo #(
	parameter int W = 17,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// Drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic                rdy;
	} vdp_fifo_st_t;
	vdp_fifo_st_t f_r;
	vdp_fifo_st_t f_nxt;
	logic push;
	logic pop;
	always_comb begin
		f_nxt = f_r;
		push = in_valid && f_r.rdy;
		pop = out_ready && (f_r.cnt != '0);
		if (push) begin
			f_nxt.mem[f_r.wp] = in_data;
			f_nxt.wp = (f_r.wp == AW'(D - 1)) ? '0 : AW'(f_r.wp + 1'b1);
		end
		if (pop)
			f_nxt.rp = (f_r.rp == AW'(D - 1)) ? '0 : AW'(f_r.rp + 1'b1);
		f_nxt.cnt = (AW+1)'(f_r.cnt + (AW+1)'(push) - (AW+1)'(pop));
		f_nxt.rdy = (f_nxt.cnt != (AW+1)'(D));
		if (rst) begin
			f_nxt = '0;
			f_nxt.rdy = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		f_r <= f_nxt;
	end
	assign in_ready  = f_r.rdy;
	assign out_valid = (f_r.cnt != '0);
	assign out_data  = f_r.mem[f_r.rp];
endmodule

module vdp_host (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial link, host end
	vdp_link_if.host         link,
	// Chip select request
	input  wire logic        enable,
	// Words to send; is_data high for samples
	input  wire logic        push_valid,
	input  wire logic [15:0] push_word,
	input  wire logic        push_is_data,
	output logic             push_ready,
	// Words received
	output logic [15:0]      rx_word,
	output logic             rx_valid
);
	typedef struct packed {
		logic        cs;
		logic        sclk_d;
		logic        serial_in_line;
		logic        in_frame_sync;
		logic        dc;
		logic [4:0]  tx_cnt;
		logic [15:0] tx_sh;
		logic [4:0]  rx_cnt;
		logic [15:0] rx_sh;
		logic [15:0] rx_word;
		logic        rx_stb;
		logic        frame_seen;
	} vdp_host_st_t;
	vdp_host_st_t h_r;
	vdp_host_st_t h_nxt;
	logic        q_valid;
	logic [16:0] q_data;
	logic        q_pop;
	logic        rise;
	logic        fall;
	logic [15:0] w;

	// Samples wait for a device frame, so the queue really backs up
	vdp_fifo #(
		.W (vdp_pkg::HOST_FIFO_W),
		.D (vdp_pkg::HOST_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push_valid),
		.in_data   ({push_is_data, push_word}),
		.in_ready  (push_ready),
		.out_valid (q_valid),
		.out_data  (q_data),
		.out_ready (q_pop)
	);

	always_comb begin
		h_nxt = h_r;
		h_nxt.cs = enable; // R11
		h_nxt.sclk_d = link.sclk_w;
		h_nxt.rx_stb = 1'b0;
		rise = link.sclk_w && !h_r.sclk_d;
		fall = !link.sclk_w && h_r.sclk_d;
		w = {h_r.rx_sh[14:0], link.sdo_w};
		q_pop = rise && h_r.cs && (h_r.tx_cnt == 5'h0) && q_valid
			&& (!q_data[16] || h_r.frame_seen);
		if (rise) begin
			h_nxt.in_frame_sync = 1'b0;
			if (h_r.tx_cnt != 5'h0) begin
				h_nxt.serial_in_line = h_r.tx_sh[15]; // R9 R14
				h_nxt.tx_sh = {h_r.tx_sh[14:0], 1'b0};
				h_nxt.tx_cnt = 5'(h_r.tx_cnt - 5'h1);
			end else if (q_pop) begin
				h_nxt.in_frame_sync = 1'b1; // R14 R17
				h_nxt.dc = q_data[16]; // R15 R17
				h_nxt.tx_sh = q_data[15:0];
				h_nxt.tx_cnt = vdp_pkg::BIT_CNT_LOAD;
				if (q_data[16])
					h_nxt.frame_seen = 1'b0;
			end
		end
		if (fall) begin
			if (h_r.rx_cnt != 5'h0) begin
				h_nxt.rx_sh = w; // R9
				h_nxt.rx_cnt = 5'(h_r.rx_cnt - 5'h1);
			end
			if (h_r.rx_cnt == 5'h1) begin
				h_nxt.rx_word = w;
				h_nxt.rx_stb = 1'b1;
			end
			if (h_r.rx_cnt <= 5'h1 && link.out_frame_sync_w) begin
				h_nxt.rx_cnt = vdp_pkg::BIT_CNT_LOAD; // R17
				h_nxt.frame_seen = 1'b1;
			end
		end
		if (rst)
			h_nxt = '0;
	end

	always_ff @(posedge clk) begin
		h_r <= h_nxt;
	end

	assign link.serial_in_line    = h_r.serial_in_line;
	assign link.in_frame_sync  = h_r.in_frame_sync;
	assign link.dc_sel = h_r.dc;
	assign link.cs     = h_r.cs;
	assign rx_word     = h_r.rx_word;
	assign rx_valid    = h_r.rx_stb;
endmodule
`default_nettype wire

// >>> vdp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module vdp_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Lines driven by the device end
	input wire logic sclk,
	input wire logic sclk_oe,
	input wire logic serial_out_line,
	input wire logic sdo_oe,
	input wire logic out_frame_sync,
	input wire logic out_frame_sync_oe,
	// Lines driven by the host end
	input wire logic serial_in_line,
	input wire logic in_frame_sync,
	input wire logic dc_sel,
	input wire logic cs
);
	// Clocks since the last output frame sync, saturating
	logic [7:0] gap_r;
	always_ff @(posedge clk) begin
		if (rst)
			gap_r <= 8'hff;
		else if ($rose(out_frame_sync))
			gap_r <= 8'h00;
		else if (gap_r != 8'hff)
			gap_r <= gap_r + 8'h01;
	end
	property p_float;
		@(posedge clk) disable iff (rst) !cs |=> !sclk_oe && !sdo_oe && !out_frame_sync_oe;
	endproperty
	a_float: assert property (p_float) else $error("outputs driven while deselected");
	property p_drive;
		@(posedge clk) disable iff (rst) cs |=> sclk_oe && sdo_oe && out_frame_sync_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("outputs floating while selected");
	property p_rst_low;
		@(posedge clk) disable iff (rst) $fell(rst) |-> !sclk && !serial_out_line && !out_frame_sync;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("lines not low in reset");
	property p_sclk_shape;
		@(posedge clk) disable iff (rst) $rose(sclk) |=> sclk ##1 !sclk [*3] ##1 sclk;
	endproperty
	a_sclk_shape: assert property (p_sclk_shape) else $error("serial clock not clk/5");
	property p_sync_len;
		@(posedge clk) disable iff (rst) $rose(out_frame_sync) |-> out_frame_sync [*5] ##1 !out_frame_sync;
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("out sync not one period");
	property p_sync_edge;
		@(posedge clk) disable iff (rst) $rose(out_frame_sync) |-> $rose(sclk);
	endproperty
	a_sync_edge: assert property (p_sync_edge) else $error("out sync off clock rise");
	property p_bit_edge;
		@(posedge clk) disable iff (rst) sdo_oe && cs && $changed(serial_out_line) |-> $rose(sclk);
	endproperty
	a_bit_edge: assert property (p_bit_edge) else $error("data changed off clock rise");
	property p_spacing;
		@(posedge clk) disable iff (rst) $rose(out_frame_sync) |-> gap_r >= 8'h54;
	endproperty
	a_spacing: assert property (p_spacing) else $error("frame shorter than 16 bits");
	property p_in_sync;
		@(posedge clk) disable iff (rst) $rose(in_frame_sync) |-> in_frame_sync [*5] ##1 !in_frame_sync;
	endproperty
	a_in_sync: assert property (p_in_sync) else $error("in sync not one period");
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk;
	logic        rst;
	logic        enable;
	logic        push_valid;
	logic [15:0] push_word;
	logic        push_is_data;
	logic        push_ready;
	logic [15:0] rx_word;
	logic        rx_valid;
	logic [15:0] adc_word;
	logic        adc_taken;
	logic [15:0] dac_sample;
	logic        dac_valid;
	logic [15:0] ctrl_word;
	logic [31:0] seed;
	logic [15:0] exp_ctrl;
	logic [15:0] w;
	logic        saw_full;
	logic        prev_sclk;
	logic        last_sdo;
	int          rises;
	int          pulses;
	int          num_errors;
	int          comparisons;
	int          cnt;
	vdp_link_if link ();
	vdp_dev u_vdp_dev (.clk(clk), .rst(rst), .link(link), .adc_word(adc_word),
		.adc_taken(adc_taken), .dac_sample(dac_sample), .dac_valid(dac_valid),
		.ctrl_word(ctrl_word));
	vdp_host u_vdp_host (.clk(clk), .rst(rst), .link(link), .enable(enable),
		.push_valid(push_valid), .push_word(push_word), .push_is_data(push_is_data),
		.push_ready(push_ready), .rx_word(rx_word), .rx_valid(rx_valid));
	vdp_chk u_vdp_chk (.clk(clk), .rst(rst), .sclk(link.sclk), .sclk_oe(link.sclk_oe),
		.serial_out_line(link.serial_out_line), .sdo_oe(link.sdo_oe), .out_frame_sync(link.out_frame_sync), .out_frame_sync_oe(link.out_frame_sync_oe),
		.serial_in_line(link.serial_in_line), .in_frame_sync(link.in_frame_sync), .dc_sel(link.dc_sel), .cs(link.cs));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [15:0] ctrl_image(input logic [15:0] wr);
		return {6'h00, wr[9:0]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic push(input logic [15:0] wd, input logic isd);
		int n = 0;
		while (push_ready !== 1'b1 && n < 2000) begin
			saw_full = 1'b1;
			@(posedge clk);
			#1;
			n++;
		end
		if (push_ready !== 1'b1)
			check(16'h0000, 16'h0001);
		push_valid = 1'b1;
		push_word = wd;
		push_is_data = isd;
		@(posedge clk);
		#1;
		push_valid = 1'b0;
		// Let an edge pass so a following push never re-raises valid in this step
		@(posedge clk);
		#1;
	endtask
	// Frames come every 3125 clocks, so a bound of 7000 covers one missed frame
	task automatic wait_rx(output logic [15:0] got);
		int n = 0;
		while (rx_valid !== 1'b1 && n < 7000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (rx_valid !== 1'b1)
			check(16'h0000, 16'h0001);
		got = rx_word;
		@(posedge clk);
		#1;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#(40 * 80000);
		num_errors++;
		report_and_stop;
	end
	initial begin
		rst = 1'b1;
		enable = 1'b0;
		push_valid = 1'b0;
		push_word = 16'h0000;
		push_is_data = 1'b0;
		seed = 32'h4843abb4;
		adc_word = 16'h8000;
		saw_full = 1'b0;
		num_errors = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		enable = 1'b1;
		// Back-to-back writes through every gain code; reserved bits random
		for (int i = 0; i < 12; i++) begin
			seed = xorshift(seed);
			exp_ctrl = {1'b0, seed[14:10], 3'(i % 8), seed[6], 2'h3, seed[3:0]};
			push(exp_ctrl, 1'b0);
		end
		cnt = 0;
		while (ctrl_word !== ctrl_image(exp_ctrl) && cnt < 3000) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		check(ctrl_word, ctrl_image(exp_ctrl));
		check({15'h0000, saw_full}, 16'h0001);
		check({15'h0000, push_ready}, 16'h0001);
		// Device samples go out MSB first and arrive whole at the host
		for (int i = 0; i < 2; i++) begin
			seed = xorshift(seed);
			adc_word = seed[15:0] | 16'h8000;
			wait_rx(w);
			if (i > 0)
				check(w, adc_word);
		end
		// Read request then read ready returns the control image
		push(16'h8000, 1'b0);
		push(16'hc000, 1'b0);
		wait_rx(w);
		if (w[15] === 1'b1)
			wait_rx(w);
		check(w, ctrl_image(exp_ctrl));
		seed = xorshift(seed);
		push(seed[15:0], 1'b1);
		cnt = 0;
		for (int i = 0; i < 2500; i++) begin
			@(posedge clk);
			#1;
			if (dac_valid === 1'b1)
				cnt++;
		end
		check(16'(cnt), 16'h0064);
		// Deselect just after a frame so no word is cut
		wait_rx(w);
		enable = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		for (int i = 0; i < 20; i++) begin
			check({13'h0000, link.sclk_w, link.sdo_w, link.out_frame_sync_w}, 16'h0000);
			@(posedge clk);
			#1;
		end
		enable = 1'b1;
		repeat (40) @(posedge clk);
		#1;
		// Powerdown: clock keeps running, no frames go out, data line holds
		exp_ctrl = exp_ctrl & 16'hffcf;
		push(exp_ctrl, 1'b0);
		cnt = 0;
		while (ctrl_word !== ctrl_image(exp_ctrl) && cnt < 3000) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		check(ctrl_word, ctrl_image(exp_ctrl));
		// A frame already due may still finish before the quiet window
		repeat (100) @(posedge clk);
		#1;
		last_sdo = link.sdo_w;
		prev_sclk = link.sclk_w;
		rises = 0;
		pulses = 0;
		for (int i = 0; i < 3500; i++) begin
			@(posedge clk);
			#1;
			if (link.sclk_w === 1'b1 && prev_sclk === 1'b0)
				rises++;
			prev_sclk = link.sclk_w;
			if (adc_taken !== 1'b0 || rx_valid !== 1'b0 || link.out_frame_sync_w !== 1'b0
					|| link.sdo_w !== last_sdo)
				pulses++;
		end
		check(16'(rises), 16'h02bc);
		check(16'(pulses), 16'h0000);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check({13'h0000, link.sclk, link.serial_out_line, link.out_frame_sync}, 16'h0000);
		check(ctrl_word, 16'h0000);
		rst = 1'b0;
		// Cleared filters with a cleared sample give silence
		pulses = 0;
		for (int i = 0; i < 700; i++) begin
			@(posedge clk);
			#1;
			if (dac_valid === 1'b1 && dac_sample !== 16'h0000)
				pulses++;
		end
		check(16'(pulses), 16'h0000);
		report_and_stop;
	end
endmodule
`default_nettype wire
